//--- rtl/nfh_pkg.sv
// package: constants for the nor flash host bus port
package nfh_pkg;
	localparam int NFH_SECTOR_WORDS_LOG2 = 16;
	localparam int NFH_ADDR_W = 26;
	localparam int NFH_DATA_W = 16;
	localparam int NFH_BYTE_DATA_W = 8;
	localparam int NFH_WBUF_MAX = 32;
	localparam int NFH_CLK_PS = 5000;
	localparam int NFH_T_SETUP_NS = 10;
	localparam int NFH_T_ACC_NS = 110;
	localparam int NFH_T_WP_NS = 35;
	localparam int NFH_T_RST_NS = 500;
	localparam int NFH_T_GAP_NS = 20;
	localparam int NFH_SETUP_CYC = (NFH_T_SETUP_NS * 1000 + NFH_CLK_PS - 1) / NFH_CLK_PS;
	localparam int NFH_ACC_CYC = (NFH_T_ACC_NS * 1000 + NFH_CLK_PS - 1) / NFH_CLK_PS;
	localparam int NFH_WP_CYC = (NFH_T_WP_NS * 1000 + NFH_CLK_PS - 1) / NFH_CLK_PS;
	localparam int NFH_RST_CYC = (NFH_T_RST_NS * 1000 + NFH_CLK_PS - 1) / NFH_CLK_PS;
	localparam int NFH_GAP_CYC = (NFH_T_GAP_NS * 1000 + NFH_CLK_PS - 1) / NFH_CLK_PS;
	localparam int NFH_CNT_W = 8;
	localparam logic [15:0] NFH_RESET_CMD = 16'h00F0;
	localparam logic NFH_STROBE_IDLE = 1'b1;
	typedef enum logic [6:0] {
		NFH_ST_IDLE = 7'h01,
		NFH_ST_SETUP = 7'h02,
		NFH_ST_READ = 7'h04,
		NFH_ST_WRITE = 7'h08,
		NFH_ST_GAP = 7'h10,
		NFH_ST_RESET = 7'h20,
		NFH_ST_DONE = 7'h40
	} nfh_state_t;
	typedef enum logic [1:0] {
		NFH_OP_READ = 2'h0,
		NFH_OP_WRITE = 2'h1,
		NFH_OP_RESET = 2'h2,
		NFH_OP_CMD_RESET = 2'h3
	} nfh_op_t;
endpackage

//--- rtl/nfh_timer.sv
// file: down counter timing the bus phases
`timescale 1ns/1ps
`default_nettype none
module nfh_timer import nfh_pkg::*; #(
	parameter int CNT_W = NFH_CNT_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	output logic expired
);
	logic [CNT_W-1:0] cnt_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	// count only: load already depends on expired, so no loop back
	assign expired = (cnt_q == '0);
endmodule // nfh_timer
`default_nettype wire

//--- rtl/nfh_host_port.sv
// file: host controller driving a parallel nor flash bus
// Overview of operation
// - commands are written as address/data sequences
// - host issues reset command when requested with op NFH_OP_CMD_RESET
// - strobe patterns for read, write, disable, reset
// - byte mode extends address with req_byte_lsb on data line 15
`timescale 1ns/1ps
`default_nettype none
module nfh_host_port import nfh_pkg::*; #(
	parameter int ADDR_W = NFH_ADDR_W,
	parameter int SETUP_CYC = NFH_SETUP_CYC,
	parameter int ACC_CYC = NFH_ACC_CYC,
	parameter int WP_CYC = NFH_WP_CYC,
	parameter int RST_CYC = NFH_RST_CYC,
	parameter int GAP_CYC = NFH_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic req_byte_lsb,
	input wire logic [NFH_DATA_W-1:0] req_wdata,
	input wire logic byte_mode,
	input wire logic guard_outer,
	output logic rsp_valid,
	output logic [NFH_DATA_W-1:0] rsp_rdata,
	output logic [ADDR_W-NFH_SECTOR_WORDS_LOG2-1:0] rsp_sector_index,
	output logic [ADDR_W-1:0] flash_addr,
	output logic chip_select_n,
	output logic output_gate_n,
	output logic write_strobe_n,
	output logic device_clear_n,
	output logic width_select_n,
	output logic sector_guard_n,
	input wire logic [NFH_DATA_W-1:0] data_lines_in,
	output logic [NFH_DATA_W-1:0] data_lines_out,
	output logic [NFH_DATA_W-1:0] data_lines_oe
);
	nfh_state_t state_q;
	nfh_op_t op_q;
	logic [NFH_DATA_W-1:0] din_s1_q, din_s2_q;
	logic [NFH_DATA_W-1:0] wdata_q;
	logic byte_q;
	logic drive_q;
	logic tmr_load;
	logic [NFH_CNT_W-1:0] tmr_val;
	logic tmr_done;

	nfh_timer #(.CNT_W(NFH_CNT_W)) u_timer (
		.clk(clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_done)
	);

	// two-stage capture of the returning data lines
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			din_s1_q <= '0;
			din_s2_q <= '0;
		end else begin
			din_s1_q <= data_lines_in;
			din_s2_q <= din_s1_q;
		end
	end

	assign req_ready = (state_q == NFH_ST_IDLE);

	// phase sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= NFH_ST_IDLE;
		end else begin
			case (state_q)
				NFH_ST_IDLE: begin
					if (req_valid) begin
						if (nfh_op_t'(req_op) == NFH_OP_RESET) begin
							state_q <= NFH_ST_RESET;
						end else begin
							state_q <= NFH_ST_SETUP;
						end
					end
				end
				NFH_ST_SETUP: begin
					if (tmr_done) begin
						state_q <= (op_q == NFH_OP_READ) ? NFH_ST_READ : NFH_ST_WRITE;
					end
				end
				NFH_ST_READ: if (tmr_done) state_q <= NFH_ST_DONE;
				NFH_ST_WRITE: if (tmr_done) state_q <= NFH_ST_GAP;
				NFH_ST_RESET: if (tmr_done) state_q <= NFH_ST_GAP;
				NFH_ST_GAP: if (tmr_done) state_q <= NFH_ST_DONE;
				NFH_ST_DONE: state_q <= NFH_ST_IDLE;
				default: state_q <= NFH_ST_IDLE;
			endcase
		end
	end

	// timer loads on every phase entry except done and idle
	always_comb begin
		tmr_load = 1'b0;
		tmr_val = '0;
		case (state_q)
			NFH_ST_IDLE: begin
				if (req_valid) begin
					tmr_load = 1'b1;
					tmr_val = (nfh_op_t'(req_op) == NFH_OP_RESET) ? NFH_CNT_W'(RST_CYC) : NFH_CNT_W'(SETUP_CYC);
				end
			end
			NFH_ST_SETUP: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_val = (op_q == NFH_OP_READ) ? NFH_CNT_W'(ACC_CYC) : NFH_CNT_W'(WP_CYC);
				end
			end
			NFH_ST_WRITE, NFH_ST_RESET: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_val = NFH_CNT_W'(GAP_CYC);
				end
			end
			default: begin
				tmr_load = 1'b0;
				tmr_val = '0;
			end
		endcase
	end

	// request capture: address, data, width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_q <= NFH_OP_READ;
			flash_addr <= '0;
			wdata_q <= '0;
			byte_q <= 1'b0;
		end else if (state_q == NFH_ST_IDLE && req_valid) begin
			op_q <= nfh_op_t'(req_op);
			byte_q <= byte_mode;
			if (nfh_op_t'(req_op) == NFH_OP_CMD_RESET) begin
				flash_addr <= '0;
				wdata_q <= NFH_RESET_CMD;
			end else begin
				flash_addr <= req_addr;
				wdata_q <= req_wdata;
			end
			if (byte_mode) begin
				wdata_q[NFH_DATA_W-1] <= req_byte_lsb;
			end
		end
	end

	// control strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chip_select_n <= NFH_STROBE_IDLE;
			output_gate_n <= NFH_STROBE_IDLE;
			write_strobe_n <= NFH_STROBE_IDLE;
			device_clear_n <= 1'b0;
		end else begin
			device_clear_n <= !(state_q == NFH_ST_IDLE && req_valid && nfh_op_t'(req_op) == NFH_OP_RESET)
				&& !(state_q == NFH_ST_RESET && !tmr_done);
			chip_select_n <= !((state_q == NFH_ST_IDLE && req_valid && nfh_op_t'(req_op) != NFH_OP_RESET)
				|| state_q == NFH_ST_SETUP || (state_q == NFH_ST_READ && !tmr_done)
				|| state_q == NFH_ST_WRITE);
			output_gate_n <= !((state_q == NFH_ST_SETUP && tmr_done && op_q == NFH_OP_READ)
				|| (state_q == NFH_ST_READ && !tmr_done));
			write_strobe_n <= !((state_q == NFH_ST_SETUP && tmr_done && op_q != NFH_OP_READ)
				|| (state_q == NFH_ST_WRITE && !tmr_done));
		end
	end

	// data drive and width pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_q <= 1'b0;
			width_select_n <= 1'b1;
			sector_guard_n <= 1'b1;
		end else begin
			// select and data held one cycle past the strobe rise
			drive_q <= (state_q == NFH_ST_SETUP && op_q != NFH_OP_READ) || state_q == NFH_ST_WRITE;
			if (state_q == NFH_ST_IDLE && req_valid) begin
				width_select_n <= !byte_mode;
			end
			sector_guard_n <= !guard_outer;
		end
	end

	assign data_lines_out = wdata_q;

	genvar gi;
	generate
		for (gi = 0; gi < NFH_DATA_W; gi++) begin : g_oe
			if (gi < NFH_BYTE_DATA_W) begin : g_lo
				assign data_lines_oe[gi] = drive_q;
			end else if (gi == NFH_DATA_W - 1) begin : g_top
				// line 15 carries the byte lane in byte mode, even on reads
				assign data_lines_oe[gi] = byte_q ? !chip_select_n : drive_q;
			end else begin : g_mid
				assign data_lines_oe[gi] = drive_q && !byte_q;
			end
		end
	endgenerate

	// answer: read data and sector index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_sector_index <= '0;
		end else begin
			rsp_valid <= (state_q == NFH_ST_DONE);
			if (state_q == NFH_ST_DONE) begin
				rsp_sector_index <= flash_addr[ADDR_W-1:NFH_SECTOR_WORDS_LOG2];
				if (op_q == NFH_OP_READ) begin
					rsp_rdata <= byte_q ? {8'h00, din_s2_q[NFH_BYTE_DATA_W-1:0]} : din_s2_q;
				end else begin
					rsp_rdata <= '0;
				end
			end
		end
	end
endmodule // nfh_host_port
`default_nettype wire

//--- testbench/nfh_host_port_props.sv
// checker: pin assertions of the host port
`timescale 1ns/1ps
`default_nettype none
module nfh_props import nfh_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic output_gate_n,
	input wire logic write_strobe_n,
	input wire logic device_clear_n,
	input wire logic width_select_n,
	input wire logic [NFH_DATA_W-1:0] data_lines_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wend;
		##[1:10] write_strobe_n ##[0:2] (data_lines_oe == 16'h0000);
	endsequence
	property p_rd;
		!output_gate_n |-> !chip_select_n && write_strobe_n && data_lines_oe[14:0] == 15'h0000;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read pins");
	property p_wr;
		!write_strobe_n |-> !chip_select_n && output_gate_n && data_lines_oe[7:0] == 8'hFF;
	endproperty
	a_wr: assert property (p_wr) else $error("bad write pins");
	property p_clr;
		!device_clear_n |-> chip_select_n && output_gate_n && write_strobe_n;
	endproperty
	a_clr: assert property (p_clr) else $error("strobe in reset");
	property p_byte;
		!width_select_n && !chip_select_n |-> data_lines_oe[15] && data_lines_oe[14:8] == 7'h00;
	endproperty
	a_byte: assert property (p_byte) else $error("bad byte lanes");
	property p_wend;
		$fell(write_strobe_n) |-> s_wend;
	endproperty
	a_wend: assert property (p_wend) else $error("write not ended");
endmodule // nfh_props
bind nfh_host_port nfh_props u_props (.*);
`default_nettype wire

//--- testbench/nfh_flash_model.sv
// model: behavioural flash device
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model import nfh_pkg::*; #(
	parameter int DLY = 0
) (
	input wire logic chip_select_n,
	input wire logic output_gate_n,
	input wire logic write_strobe_n,
	input wire logic device_clear_n,
	input wire logic width_select_n,
	input wire logic sector_guard_n,
	input wire logic [NFH_ADDR_W-1:0] addr,
	input wire logic [NFH_DATA_W-1:0] dq_in,
	output logic [NFH_DATA_W-1:0] dq_out,
	output logic [NFH_DATA_W-1:0] dq_oe,
	output logic [NFH_DATA_W-1:0] last_cmd
);
	logic [15:0] mem [int];
	logic [15:0] w;
	logic [15:0] r;
	int wr_n = 0;
	always @(posedge write_strobe_n) begin
		if (!chip_select_n && device_clear_n) begin
			last_cmd = dq_in;
			if (dq_in != NFH_RESET_CMD && (sector_guard_n || ~&addr[25:16])) begin
				mem[addr] = dq_in;
			end
			wr_n++;
		end
	end
	always @(addr, dq_in, width_select_n, wr_n) begin
		w = mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h3C5A;
		r = width_select_n ? w : {8'h00, dq_in[15] ? w[15:8] : w[7:0]};
	end
	assign #(DLY) dq_out = r;
	assign dq_oe = (!chip_select_n && !output_gate_n && write_strobe_n && device_clear_n) ?
		(width_select_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
endmodule // nfh_flash_model
`default_nettype wire

//--- testbench/tb_nor_flash_host_bus_port.sv
// testbench: host port against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb_nor_flash_host_bus_port import nfh_pkg::*;;
	logic clk, rst, req_valid, req_ready, req_byte_lsb, byte_mode, guard_outer, rsp_valid;
	logic chip_select_n, output_gate_n, write_strobe_n, device_clear_n, width_select_n, sector_guard_n;
	logic [1:0] req_op;
	logic [25:0] req_addr, flash_addr;
	logic [9:0] rsp_sector_index;
	logic [15:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out, data_lines_oe;
	logic [15:0] dev_out, dev_oe, last_cmd, r;
	logic [15:0] junk = 16'h5A5A;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	nfh_host_port u_dut (.*);
	nfh_flash_model #(.DLY(40)) u_mem (.chip_select_n, .output_gate_n, .write_strobe_n, .device_clear_n,
		.width_select_n, .sector_guard_n, .addr(flash_addr), .dq_in(data_lines_in), .dq_out(dev_out),
		.dq_oe(dev_oe), .last_cmd);
	assign data_lines_in = (data_lines_oe & data_lines_out) | (~data_lines_oe & dev_oe & dev_out)
		| (~data_lines_oe & ~dev_oe & junk);
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		junk <= ~junk;
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic [1:0] op, input logic [25:0] a, input logic l, input logic [15:0] d);
		int n;
		@(posedge clk);
		#1 req_op = op;
		req_addr = a;
		req_byte_lsb = l;
		req_wdata = d;
		req_valid = 1'b1;
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		#1 req_valid = 1'b0;
		for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) @(negedge clk);
		r = rsp_rdata;
		if (n == 400) begin
			chk(16'h0000, 16'hFFFF);
			end_sim();
		end
	endtask
	task automatic t_rw();
		xfer(2'h1, 26'h0031234, 1'b0, 16'hBEEF);
		xfer(2'h0, 26'h0031234, 1'b0, 16'h0000);
		chk(r, 16'hBEEF);
		chk({6'h00, rsp_sector_index}, 16'h0003);
		xfer(2'h0, 26'h003FFFF, 1'b0, 16'h0000);
		chk(r, 16'hC3A5);
		$display("t_rw done");
	endtask
	task automatic t_guard();
		@(posedge clk) #1 guard_outer = 1'b1;
		xfer(2'h1, 26'h3FF0010, 1'b0, 16'h1234);
		chk({15'h0000, sector_guard_n}, 16'h0000);
		xfer(2'h0, 26'h3FF0010, 1'b0, 16'h0000);
		chk(r, 16'h3C4A);
		@(posedge clk) #1 guard_outer = 1'b0;
		xfer(2'h1, 26'h3FF0010, 1'b0, 16'h1234);
		xfer(2'h0, 26'h3FF0010, 1'b0, 16'h0000);
		chk(r, 16'h1234);
		$display("t_guard done");
	endtask
	task automatic t_byte();
		xfer(2'h1, 26'h0020002, 1'b0, 16'hA1B2);
		@(posedge clk) #1 byte_mode = 1'b1;
		xfer(2'h0, 26'h0020002, 1'b0, 16'h0000);
		chk(r, 16'h00B2);
		chk({15'h0000, width_select_n}, 16'h0000);
		xfer(2'h0, 26'h0020002, 1'b1, 16'h0000);
		chk(r, 16'h00A1);
		@(posedge clk) #1 byte_mode = 1'b0;
		$display("t_byte done");
	endtask
	task automatic t_rst();
		xfer(2'h3, 26'h0000000, 1'b0, 16'h0000);
		chk(last_cmd, NFH_RESET_CMD);
		xfer(2'h0, 26'h0000000, 1'b0, 16'h0000);
		chk(r, 16'h3C5A);
		xfer(2'h2, 26'h0000000, 1'b0, 16'h0000);
		xfer(2'h0, 26'h0031234, 1'b0, 16'h0000);
		chk(r, 16'hBEEF);
		$display("t_rst done");
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		{rst, req_valid, req_op, req_addr, req_byte_lsb, req_wdata, byte_mode, guard_outer} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		t_rw();
		t_guard();
		t_byte();
		t_rst();
		end_sim();
	end
endmodule // tb_nor_flash_host_bus_port
`default_nettype wire
